// ==== hw/lin_uart_command_header_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Header, response and UART functions share services
// - New identifier raises identifier ready flag
// - Flags mark identifiers 60 to 63
// - Four LIN events: id, rx, tx, error
// - Identifiers 62, 63 flagged as extended frames
// - UART full duplex with local loopback
// - Shift register plus holding byte; one tx byte
// - Data access updates flags automatically
// - Fine baud divisor keeps error small
// - Clearing enable stops everything at once
// - LIN commands; field returns to zero after
// - Byte commands; no checksum, no timeout, lengths zero
// - Background header reception sets flags, legacy length
// - Clearing command aborts and sets abort flag
// - Break detect, sync resync, parity, timeout, integrity
// - Header sent at programmed bit rate, or at last resynced rate in LIN mode
// - Break of 13 dominant bits, then 0x55
// - Identifier byte includes generated parity bits
// - After header: flags, back to idle, length
// - Header start arms timeout, compares bus
// - Legacy select chooses classic protocol rules
// - Identifiers 60 to 63 use classic checksum
// - Single clock for the whole controller
module lin_uart_command_header_ctrl
   import lin_uart_pkg::*;
#(
   parameter int MAX_LEN = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Serial line to the transceiver
   input wire logic rxd,
   output logic txd
);

   typedef enum logic [2:0] {
      H_BRK = 3'b001,
      H_SYNC = 3'b010,
      H_ID = 3'b100
   } hdr_e;

   if (MAX_LEN < 1 || MAX_LEN > 8) begin : g_len_check
      $error("MAX_LEN must lie in 1..8");
   end

   function automatic logic [1:0] id_parity(input logic [5:0] id);
      id_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
   endfunction : id_parity

   function automatic logic [7:0] cks_add(input logic [7:0] s, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, s} + {1'b0, b};
      cks_add = t[7:0] + {7'h00, t[8]};
   endfunction : cks_add

   function automatic logic [3:0] clamp_len(input logic [3:0] n);
      clamp_len = (n > 4'(MAX_LEN)) ? 4'(MAX_LEN) : n;
   endfunction : clamp_len

   // Allowed frame time is 1.4 times the nominal, in bit times
   function automatic logic [8:0] tmo_limit(input logic [3:0] n);
      tmo_limit = 9'((14 * (34 + 10 * (int'(n) + 1))) / 10);
   endfunction : tmo_limit

   ctrl_s ctrl_q;
   err_s err_q;
   logic [7:0] btr_q, dlr_q, idr_q, rx_hold_q, tx_hold_q, bitlen_q, rdata_q, rd_mux;
   logic [15:0] brr_q, div_q, low_q;
   logic rx_ok_q, tx_ok_q, id_ok_q, rx_full_q, tx_pend_q, txd_q;
   hdr_e hdr_q;
   logic rx_prev_q, rx_act_q;
   logic [7:0] rx_scnt_q, rx_sh_q, tx_scnt_q, bt_q, sum_q;
   logic [3:0] rx_bit_q, tx_left_q, rsp_cnt_q;
   logic [13:0] tx_sh_q;
   logic tx_brk_q, cks_sent_q, frm_run_q;
   logic [1:0] step_q;
   logic [2:0] fall_q;
   logic [11:0] sync_cnt_q;
   logic [8:0] frm_q;

   // Bus decode
   ctrl_s wctrl;
   assign wctrl = ctrl_s'(wdata);
   wire wr_ctrl = wr & (addr == ADDR_CTRL);
   wire wr_stat = wr & (addr == ADDR_STAT);
   wire wr_err = wr & (addr == ADDR_ERR);
   wire wr_dat = wr & (addr == ADDR_DAT);
   wire rd_dat = rd & (addr == ADDR_DAT);

   // Mode decode
   wire enabled = ctrl_q.controller_enable_bit;
   wire [2:0] cmd = ctrl_q.command_field;
   wire lin_mode = enabled & ~cmd[CMD_UART_BIT];
   wire uart_mode = enabled & cmd[CMD_UART_BIT];
   wire in_txh = lin_mode & (cmd == CMD_TXH);
   wire in_rxr = lin_mode & (cmd == CMD_RXR);
   wire in_txr = lin_mode & (cmd == CMD_TXR);
   wire [3:0] rx_len = clamp_len(dlr_q[3:0]);
   wire [3:0] tx_len = clamp_len(dlr_q[7:4]);
   wire [7:0] half = {1'b0, bitlen_q[7:1]};
   wire [7:0] last_smp = bitlen_q - 8'h01;

   wire sw_abort = wr_ctrl & lin_mode & (cmd[1:0] != 2'b00) & wctrl.controller_enable_bit
                   & ~wctrl.command_field[CMD_UART_BIT] & (wctrl.command_field[1:0] == 2'b00);
   wire rsp_init = wr_ctrl & ~wctrl.command_field[CMD_UART_BIT] & wctrl.command_field[1];
   wire txh_init = wr_ctrl & (wctrl.command_field == CMD_TXH);

   // fractional-free sample tick from 16-bit divisor
   wire tick = enabled & (div_q == brr_q);

   wire rx_in = (uart_mode & ctrl_q.loopback) ? txd_q : rxd;
   wire rx_fall = tick & rx_prev_q & ~rx_in;
   wire rx_en = lin_mode ? (hdr_q != H_SYNC) : (uart_mode & cmd[CMD_RXEN_BIT]);
   wire rx_mid = tick & rx_act_q & (rx_scnt_q == half);
   wire rx_stop = rx_mid & (rx_bit_q == STOP_BIT_IDX);
   wire rx_done = rx_stop & rx_in;
   wire rx_ferr = rx_stop & ~rx_in;

   // break is a low run of at least 11 nominal bits
   wire [15:0] brk_need = BRK_DET_BITS * {8'h00, btr_q};
   wire brk_det = lin_mode & tick & rx_in & (low_q >= brk_need);
   wire [11:0] sync_meas = sync_cnt_q + 12'h001;
   wire [7:0] sync_len = sync_meas[10:3];
   wire sync_fin = (hdr_q == H_SYNC) & rx_fall & (fall_q == SYNC_LAST_FALL);
   wire sync_bad = (hdr_q == H_SYNC) & ((sync_fin & (sync_len < BTR_MIN)) | (&sync_cnt_q));
   wire id_take = lin_mode & (hdr_q == H_ID) & rx_done;
   wire par_ok = id_parity(rx_sh_q[5:0]) == rx_sh_q[7:6];

   // Transmit service
   wire tx_busy = tx_left_q != 4'h0;
   wire tx_bit_end = tick & tx_busy & (tx_scnt_q == last_smp);
   wire tx_byte_done = tx_bit_end & (tx_left_q == 4'h1) & ~tx_brk_q;
   wire txh_load = in_txh & (step_q != 2'h3) & ~tx_busy;
   wire cks_load = in_txr & ~tx_busy & (rsp_cnt_q == tx_len) & ~cks_sent_q;
   wire tx_allow = lin_mode ? (in_txr & (rsp_cnt_q < tx_len)) : (uart_mode & cmd[CMD_TXEN_BIT]);
   wire dat_load = ~tx_busy & tx_pend_q & tx_allow & ~wr_dat;
   wire [7:0] load_byte = txh_load ? ((step_q == 2'h1) ? SYNC_CHAR : idr_q)
                        : cks_load ? ~sum_q : tx_hold_q;
   // bus compared against own bit at mid-sample
   wire bit_fail = (in_txh | in_txr) & tick & tx_busy & (tx_scnt_q == half)
                   & (rx_in != tx_sh_q[0]);

   // Response function
   wire rx_take = in_rxr & (hdr_q == H_BRK) & rx_done;
   wire rx_data = rx_take & (rsp_cnt_q < rx_len);
   wire rx_cks = rx_take & ~rx_data;
   wire rx_cks_ok = rx_sh_q == ~sum_q;
   wire rsp_ferr = in_rxr & (hdr_q == H_BRK) & rx_ferr;
   wire bit_en = tick & (bt_q == last_smp);
   wire tmo_err = frm_run_q & (in_rxr | in_txr) & (frm_q >= tmo_limit(in_rxr ? rx_len : tx_len));
   wire txr_done = in_txr & tx_byte_done & cks_sent_q;
   wire fn_abort = sw_abort | bit_fail | tmo_err | rsp_ferr;
   // field returns to receive header after a function
   // header sent, command back to zero
   wire fn_end = (in_txh & id_take) | rx_cks | txr_done | bit_fail | tmo_err | rsp_ferr;
   wire [1:0] dec_len = (rx_sh_q[5:4] == 2'b00) ? 2'h1 : rx_sh_q[5:4];
   wire [3:0] legacy_len = 4'h1 << dec_len;
   wire uart_rx = uart_mode & rx_done;

   err_s err_set;
   always_comb begin
      err_set = '0;
      err_set.abort_flag = sw_abort;
      err_set.parity = id_take & ~par_ok;
      err_set.bit_err = bit_fail;
      err_set.framing = rsp_ferr | (uart_mode & rx_ferr);
      err_set.overrun = (uart_rx | rx_data) & rx_full_q & ~rd_dat;
      err_set.sync = sync_bad;
      err_set.checksum = rx_cks & ~rx_cks_ok;
      err_set.timeout = tmo_err;
   end

   stat_s stat;
   always_comb begin
      stat = '0;
      stat.response_received_flag = rx_ok_q;
      stat.response_sent_flag = tx_ok_q;
      stat.identifier_ready_flag = id_ok_q;
      stat.error_event_flag = |err_q;
      stat.busy = tx_busy | rx_act_q;
      stat.id_special = idr_q[5:0] >= SPECIAL_ID_MIN;
      stat.id_extended = idr_q[5:0] >= EXT_ID_MIN;
   end

   always_comb begin
      unique case (addr)
         ADDR_CTRL: rd_mux = ctrl_q;
         ADDR_STAT: rd_mux = stat;
         ADDR_ERR: rd_mux = err_q;
         ADDR_BTR: rd_mux = btr_q;
         ADDR_BRRL: rd_mux = brr_q[7:0];
         ADDR_BRRH: rd_mux = brr_q[15:8];
         // lengths read zero in byte commands
         ADDR_DLR: rd_mux = cmd[CMD_UART_BIT] ? 8'h00 : dlr_q;
         ADDR_IDR: rd_mux = idr_q;
         ADDR_DAT: rd_mux = rx_hold_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      rdata_q <= rd ? rd_mux : 8'h00;
   end

   // reset disables and idles the controller
   // enable written low takes effect with no wait
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= ctrl_s'(CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= wctrl;
      end else if (fn_end) begin
         ctrl_q.command_field <= CMD_RXH;
      end
   end

   // Set wins over clear on every sticky bit
   always_ff @(posedge clk) begin
      if (srst) begin
         err_q <= err_s'(ERR_RST);
         rx_ok_q <= 1'b0;
         tx_ok_q <= 1'b0;
         id_ok_q <= 1'b0;
      end else begin
         err_q <= (err_q & ~(wr_err ? err_s'(wdata) : err_s'(8'h00))) | err_set;
         // reading data clears the receive flag
         rx_ok_q <= (rx_ok_q & ~(wr_stat & wdata[STAT_RXOK_BIT]) & ~rd_dat)
                    | uart_rx | (rx_cks & rx_cks_ok);
         // writing data clears the transmit flag
         tx_ok_q <= (tx_ok_q & ~(wr_stat & wdata[STAT_TXOK_BIT]) & ~wr_dat)
                    | (uart_mode & tx_byte_done) | txr_done;
         // identifier ready for both header directions
         id_ok_q <= (id_ok_q & ~(wr_stat & wdata[STAT_IDOK_BIT])) | (id_take & par_ok);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         btr_q <= BTR_RST;
         brr_q <= BRR_RST;
         idr_q <= IDR_RST;
         dlr_q <= DLR_RST;
      end else begin
         if (wr & (addr == ADDR_BTR) & (wdata >= BTR_MIN)) btr_q <= wdata;
         if (wr & (addr == ADDR_BRRL)) brr_q[7:0] <= wdata;
         if (wr & (addr == ADDR_BRRH)) brr_q[15:8] <= wdata;
         if (id_take) begin
            idr_q <= rx_sh_q;
         end else if (wr & (addr == ADDR_IDR)) begin
            idr_q <= {id_parity(wdata[5:0]), wdata[5:0]};
         end
         // legacy select governs length and checksum
         if (uart_mode) begin
            dlr_q <= 8'h00;
         end else if (id_take & ctrl_q.legacy_protocol_select) begin
            dlr_q <= {legacy_len, legacy_len};
         end else if (wr & (addr == ADDR_DLR)) begin
            dlr_q <= wdata;
         end
      end
   end

   // receive holding byte behind shift register
   always_ff @(posedge clk) begin
      if (srst | ~enabled) begin
         rx_full_q <= 1'b0;
         rx_hold_q <= 8'h00;
      end else if (uart_rx | rx_data) begin
         rx_full_q <= 1'b1;
         rx_hold_q <= rx_sh_q;
      end else if (rd_dat) begin
         rx_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst | ~enabled) begin
         tx_pend_q <= 1'b0;
         tx_hold_q <= 8'h00;
      end else begin
         tx_pend_q <= wr_dat | (tx_pend_q & ~dat_load);
         if (wr_dat) tx_hold_q <= wdata;
      end
   end

   // all timing derives from clk via enables
   always_ff @(posedge clk) begin
      if (srst | ~enabled | tick) div_q <= 16'h0000;
      else div_q <= div_q + 16'h0001;
      if (srst | ~enabled | bit_en) bt_q <= 8'h00;
      else if (tick) bt_q <= bt_q + 8'h01;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bitlen_q <= BTR_RST;
      end else if (~lin_mode | (wr & (addr == ADDR_BTR) & (wdata >= BTR_MIN))) begin
         bitlen_q <= (wr & (addr == ADDR_BTR) & (wdata >= BTR_MIN)) ? wdata : btr_q;
      end else if (sync_fin & ~sync_bad) begin
         bitlen_q <= sync_len;
      end
   end

   always_ff @(posedge clk) begin
      if (srst | ~lin_mode) begin
         hdr_q <= H_BRK;
      end else if (brk_det) begin
         hdr_q <= H_SYNC;
      end else begin
         unique case (hdr_q)
            H_BRK: hdr_q <= H_BRK;
            H_SYNC: if (sync_bad) hdr_q <= H_BRK; else if (sync_fin) hdr_q <= H_ID;
            H_ID: if (rx_done | rx_ferr) hdr_q <= H_BRK;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst | (hdr_q != H_SYNC)) begin
         fall_q <= 3'h0;
         sync_cnt_q <= 12'h000;
      end else if (tick) begin
         if (rx_fall) fall_q <= fall_q + 3'h1;
         if (fall_q != 3'h0 && !(&sync_cnt_q)) sync_cnt_q <= sync_cnt_q + 12'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst | ~lin_mode) begin
         low_q <= 16'h0000;
      end else if (tick) begin
         low_q <= rx_in ? 16'h0000 : (&low_q ? low_q : low_q + 16'h0001);
      end
   end

   // shared receive service
   // Edge history runs through sync, else a false start follows it
   always_ff @(posedge clk) begin
      if (srst | ~enabled) rx_prev_q <= 1'b1;
      else if (tick) rx_prev_q <= rx_in;
      if (srst | ~rx_en) begin
         rx_act_q <= 1'b0;
         rx_scnt_q <= 8'h00;
         rx_bit_q <= 4'h0;
      end else if (~rx_act_q) begin
         if (rx_fall) begin
            rx_act_q <= 1'b1;
            rx_scnt_q <= 8'h01;
            rx_bit_q <= 4'h0;
         end
      end else if (tick) begin
         rx_scnt_q <= (rx_scnt_q == last_smp) ? 8'h00 : rx_scnt_q + 8'h01;
         if (rx_mid) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if ((rx_bit_q == 4'h0 && rx_in) || rx_stop) rx_act_q <= 1'b0;
            else if (rx_bit_q != 4'h0) rx_sh_q <= {rx_in, rx_sh_q[7:1]};
         end
      end
   end

   // header queued at bitlen_q rate: programmed, or resynced by a received sync
   always_ff @(posedge clk) begin
      if (srst | txh_init) step_q <= 2'h0;
      else if (txh_load) step_q <= step_q + 2'h1;
   end

   // Shared transmit service
   always_ff @(posedge clk) begin
      if (srst | ~enabled | fn_abort) begin
         tx_left_q <= 4'h0;
         tx_scnt_q <= 8'h00;
         tx_brk_q <= 1'b0;
         tx_sh_q <= '1;
      end else if (txh_load & (step_q == 2'h0)) begin
         // thirteen dominant bits then a recessive delimiter
         tx_sh_q <= {1'b1, 13'h0000};
         tx_left_q <= BRK_TX_BITS + 4'h1;
         tx_scnt_q <= 8'h00;
         tx_brk_q <= 1'b1;
      end else if (txh_load | cks_load | dat_load) begin
         tx_sh_q <= {4'hF, 1'b1, load_byte, 1'b0};
         tx_left_q <= BYTE_FRAME_BITS;
         tx_scnt_q <= 8'h00;
         tx_brk_q <= 1'b0;
      end else if (tick & tx_busy) begin
         if (tx_bit_end) begin
            tx_scnt_q <= 8'h00;
            tx_sh_q <= {1'b1, tx_sh_q[13:1]};
            tx_left_q <= tx_left_q - 4'h1;
         end else begin
            tx_scnt_q <= tx_scnt_q + 8'h01;
         end
      end
   end

   // recessive line unless a frame is shifting
   always_ff @(posedge clk) begin
      if (srst) txd_q <= 1'b1;
      else txd_q <= (enabled & tx_busy) ? tx_sh_q[0] : 1'b1;
   end

   // classic sum for legacy or special identifiers
   always_ff @(posedge clk) begin
      if (srst) begin
         sum_q <= 8'h00;
         rsp_cnt_q <= 4'h0;
         cks_sent_q <= 1'b0;
      end else if (rsp_init) begin
         sum_q <= (ctrl_q.legacy_protocol_select | (idr_q[5:0] >= SPECIAL_ID_MIN)) ? 8'h00 : idr_q;
         rsp_cnt_q <= 4'h0;
         cks_sent_q <= 1'b0;
      end else if (rx_data | (dat_load & in_txr)) begin
         sum_q <= cks_add(sum_q, rx_data ? rx_sh_q : tx_hold_q);
         rsp_cnt_q <= rsp_cnt_q + 4'h1;
      end else if (cks_load) begin
         cks_sent_q <= 1'b1;
      end
   end

   // frame timer only runs for LIN functions
   always_ff @(posedge clk) begin
      if (srst | ~lin_mode | fn_end) begin
         frm_run_q <= 1'b0;
         frm_q <= 9'h000;
      end else if (brk_det) begin
         frm_run_q <= 1'b1;
         frm_q <= 9'h000;
      end else if (bit_en & frm_run_q & ~(&frm_q)) begin
         frm_q <= frm_q + 9'h001;
      end
   end

   assign rdata = rdata_q;
   assign txd = txd_q;

endmodule : lin_uart_command_header_ctrl

// ==== hw/lin_uart_pkg.sv ====
package lin_uart_pkg;

   // Register word addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_ERR = 4'h2;
   localparam logic [3:0] ADDR_BTR = 4'h3;
   localparam logic [3:0] ADDR_BRRL = 4'h4;
   localparam logic [3:0] ADDR_BRRH = 4'h5;
   localparam logic [3:0] ADDR_DLR = 4'h6;
   localparam logic [3:0] ADDR_IDR = 4'h7;
   localparam logic [3:0] ADDR_DAT = 4'h8;

   // Values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] ERR_RST = 8'h00;
   localparam logic [7:0] BTR_RST = 8'h20;
   localparam logic [15:0] BRR_RST = 16'h0000;
   localparam logic [7:0] DLR_RST = 8'h00;
   localparam logic [7:0] IDR_RST = 8'h80;

   // Command field codes; bit 2 selects the byte (UART) commands
   localparam logic [2:0] CMD_RXH = 3'h0;
   localparam logic [2:0] CMD_TXH = 3'h1;
   localparam logic [2:0] CMD_RXR = 3'h2;
   localparam logic [2:0] CMD_TXR = 3'h3;
   localparam int CMD_UART_BIT = 2;
   localparam int CMD_RXEN_BIT = 0;
   localparam int CMD_TXEN_BIT = 1;

   // Status write-one-to-clear positions
   localparam int STAT_RXOK_BIT = 0;
   localparam int STAT_TXOK_BIT = 1;
   localparam int STAT_IDOK_BIT = 2;

   // Line timing, in bit times and samples
   localparam logic [3:0] BRK_TX_BITS = 4'hD;
   localparam logic [15:0] BRK_DET_BITS = 16'h000B;
   localparam logic [7:0] BTR_MIN = 8'h08;
   localparam logic [7:0] SYNC_CHAR = 8'h55;
   localparam logic [2:0] SYNC_LAST_FALL = 3'h4;
   localparam logic [3:0] BYTE_FRAME_BITS = 4'hA;
   localparam logic [3:0] STOP_BIT_IDX = 4'h9;
   localparam logic [5:0] SPECIAL_ID_MIN = 6'h3C;
   localparam logic [5:0] EXT_ID_MIN = 6'h3E;

   typedef struct packed {
      logic [1:0] spare;
      logic loopback;
      logic legacy_protocol_select;
      logic controller_enable_bit;
      logic [2:0] command_field;
   } ctrl_s;

   typedef struct packed {
      logic timeout;
      logic checksum;
      logic sync;
      logic overrun;
      logic framing;
      logic bit_err;
      logic parity;
      logic abort_flag;
   } err_s;

   typedef struct packed {
      logic spare;
      logic id_extended;
      logic id_special;
      logic busy;
      logic error_event_flag;
      logic identifier_ready_flag;
      logic response_sent_flag;
      logic response_received_flag;
   } stat_s;

endpackage : lin_uart_pkg

// ==== verification/lin_bus_node.sv ====
`timescale 1ns/1ps
module lin_bus_node (
   // Clock
   input wire logic clk,
   // Bus side
   input wire logic txd,
   output logic rxd
);
   logic drive_q = 1'b1;

   // Wired-AND bus with pull-up: a dominant low from either node wins
   assign rxd = txd & drive_q;

   task automatic hold_bits(input logic lvl, input int bits, input int bit_clks);
      drive_q <= lvl;
      repeat (bits * bit_clks) @(posedge clk);
   endtask : hold_bits

   task automatic send_byte(input logic [7:0] b, input int bit_clks);
      hold_bits(1'b0, 1, bit_clks);
      for (int i = 0; i < 8; i++) begin
         hold_bits(b[i], 1, bit_clks);
      end
      hold_bits(1'b1, 1, bit_clks);
   endtask : send_byte

   // wake-up byte of five dominant bits
   task automatic send_wake(input int bit_clks);
      send_byte(8'hF0, bit_clks);
   endtask : send_wake

   // remote master header: break, delimiter, sync, identifier
   task automatic send_header(input logic [7:0] pid, input int bit_clks);
      hold_bits(1'b0, 13, bit_clks);
      hold_bits(1'b1, 1, bit_clks);
      send_byte(8'h55, bit_clks);
      send_byte(pid, bit_clks);
   endtask : send_header
endmodule : lin_bus_node

// ==== verification/lin_uart_command_header_ctrl_sva.sv ====
`timescale 1ns/1ps
module lin_uart_command_header_ctrl_sva
   import lin_uart_pkg::*;
#(
   parameter int MAX_LEN = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // Serial line
   input wire logic rxd,
   input wire logic txd
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Shadows of software writes; the device only ever clears cmd itself
   logic [7:0] ctrl_q;
   logic [7:0] btr_q;
   logic [15:0] brr_q;
   logic [23:0] low_q;
   wire logic [23:0] bit_clks = btr_q * (brr_q + 24'd1);
   wire logic cmd_idle = ctrl_q[3] && ctrl_q[2:0] == CMD_RXH;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RST;
         btr_q <= BTR_RST;
         brr_q <= BRR_RST;
         low_q <= '0;
      end else begin
         if (wr && addr == ADDR_CTRL) ctrl_q <= wdata;
         if (wr && addr == ADDR_BTR && wdata >= BTR_MIN) btr_q <= wdata;
         if (wr && addr == ADDR_BRRL) brr_q[7:0] <= wdata;
         if (wr && addr == ADDR_BRRH) brr_q[15:8] <= wdata;
         low_q <= txd ? 24'd0 : low_q + 24'd1;
      end
   end

   chk_reset_line_high: assert property ($fell(srst) |-> txd ##1 txd)
      else $error("txd not recessive after reset");
   chk_disabled_line_high: assert property (!ctrl_q[3] && !$past(ctrl_q[3]) |-> txd)
      else $error("txd driven while disabled");
   chk_abort_line_high: assert property (cmd_idle && $past(cmd_idle) |-> txd)
      else $error("txd driven in receive header state");
   chk_ctrl_read_back: assert property ($past(rd) && $past(addr) == ADDR_CTRL
      |-> rdata[4:3] == ctrl_q[4:3])
      else $error("control enable or protocol bit lost");
   chk_byte_cmd_kept: assert property ($past(rd) && $past(addr) == ADDR_CTRL && ctrl_q[2]
      |-> rdata[2:0] == ctrl_q[2:0])
      else $error("byte command field changed");
   chk_length_read_only: assert property ($past(rd) && $past(addr) == ADDR_DLR && ctrl_q[2]
      |-> rdata == 8'h00)
      else $error("length register not zero in byte mode");
   chk_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   chk_break_length: assert property ($rose(txd) && low_q > 10 * bit_clks
      |-> low_q + 1 >= 13 * bit_clks && low_q <= 13 * bit_clks + 1)
      else $error("break length wrong");
   chk_break_delimiter: assert property ($rose(txd) && low_q > 10 * bit_clks
      |-> txd [*7])
      else $error("break delimiter too short");

   cover property ($rose(txd) && low_q > 10 * bit_clks);
   cover property (wr && addr == ADDR_CTRL && ctrl_q[2:0] == CMD_TXH && wdata[2:0] == CMD_RXH);
   cover property ($past(rd) && $past(addr) == ADDR_DLR && ctrl_q[2]);
   cover property ($fell(rxd) && txd);
endmodule : lin_uart_command_header_ctrl_sva

bind lin_uart_command_header_ctrl lin_uart_command_header_ctrl_sva #(.MAX_LEN(MAX_LEN)) i_sva (
   .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .rxd(rxd), .txd(txd));

// ==== verification/lin_uart_command_header_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module lin_uart_command_header_ctrl_tb_top
   import lin_uart_pkg::*;
;
   logic clk;
   logic srst;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic rxd;
   logic txd;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;

   lin_uart_command_header_ctrl #(.MAX_LEN(8)) i_lin_uart_command_header_ctrl (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rxd(rxd), .txd(txd));
   lin_bus_node i_lin_bus_node (.clk(clk), .txd(txd), .rxd(rxd));

   function automatic logic [7:0] pid(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction : pid

   function automatic logic [7:0] stat_exp(input logic [5:0] i);
      return {1'b0, i >= EXT_ID_MIN, i >= SPECIAL_ID_MIN, 2'b00, 1'b1, 2'b00};
   endfunction : stat_exp

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   // Read data only stand in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : rd_reg

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m,
                         input string what);
      logic [7:0] d;
      rd_reg(a, d);
      check(what, d & m, exp & m);
   endtask : rd_chk

   task automatic wait_cmd_idle(input logic [7:0] exp);
      logic [7:0] d;
      d = 8'hFF;
      for (int n = 0; n < 300 && d[1:0] !== 2'b00; n++) begin
         rd_reg(ADDR_CTRL, d);
      end
      check("ctrl", d, exp);
   endtask : wait_cmd_idle

   task automatic t_reset;
      rd_chk(ADDR_CTRL, CTRL_RST, 8'hFF, "ctrl");
      rd_chk(ADDR_ERR, ERR_RST, 8'hFF, "err");
      rd_chk(ADDR_STAT, 8'h00, 8'hFF, "stat");
      rd_chk(ADDR_BRRH, BRR_RST[15:8], 8'hFF, "brrh");
      rd_chk(ADDR_IDR, IDR_RST, 8'hFF, "idr");
      rd_chk(4'hF, 8'h00, 8'hFF, "unmapped");
      wr_reg(ADDR_BTR, 8'h07);
      rd_chk(ADDR_BTR, BTR_RST, 8'hFF, "btr");
      wr_reg(ADDR_BTR, BTR_MIN);
      wr_reg(ADDR_BRRL, 8'h00);
   endtask : t_reset

   task automatic t_tx_header;
      logic [5:0] ids [3] = '{6'h05, 6'h3C, 6'h3F};
      foreach (ids[k]) begin
         wr_reg(ADDR_STAT, 8'h07);
         wr_reg(ADDR_IDR, {2'b00, ids[k]});
         rd_chk(ADDR_IDR, pid(ids[k]), 8'hFF, "idr");
         wr_reg(ADDR_CTRL, 8'h18);
         wr_reg(ADDR_CTRL, {5'b00011, CMD_TXH});
         wait_cmd_idle(8'h18);
         rd_chk(ADDR_STAT, stat_exp(ids[k]), 8'h64, "stat");
         rd_chk(ADDR_DLR, ids[k] >= 6'h30 ? 8'h88 : 8'h22, 8'hFF, "dlr");
         rd_chk(ADDR_ERR, 8'h00, 8'hFF, "err");
      end
   endtask : t_tx_header

   task automatic t_abort;
      wr_reg(ADDR_STAT, 8'h07);
      wr_reg(ADDR_CTRL, {5'b00001, CMD_TXH});
      repeat (40) @(posedge clk);
      wr_reg(ADDR_CTRL, 8'h08);
      rd_chk(ADDR_ERR, 8'h01, 8'h01, "abort");
      rd_chk(ADDR_STAT, 8'h08, 8'h0C, "err event");
      wr_reg(ADDR_ERR, 8'hFF);
      wr_reg(ADDR_CTRL, {5'b00001, CMD_TXH});
      repeat (40) @(posedge clk);
      wr_reg(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_CTRL, 8'h00, 8'hFF, "disable");
      wr_reg(ADDR_ERR, 8'hFF);
   endtask : t_abort

   task automatic t_rx_header;
      wr_reg(ADDR_STAT, 8'h07);
      wr_reg(ADDR_CTRL, 8'h08);
      i_lin_bus_node.send_header(pid(6'h3E), 10);
      repeat (20) @(posedge clk);
      rd_chk(ADDR_STAT, 8'h64, 8'h64, "rx stat");
      rd_chk(ADDR_IDR, pid(6'h3E), 8'hFF, "rx idr");
      rd_chk(ADDR_ERR, 8'h00, 8'hFF, "rx err");
      wr_reg(ADDR_DLR, 8'h01);
      wr_reg(ADDR_CTRL, {5'b00001, CMD_RXR});
      i_lin_bus_node.send_byte(8'h12, 10);
      // Classic sum over data only for this identifier
      i_lin_bus_node.send_byte(8'hED, 10);
      rd_chk(ADDR_STAT, 8'h01, 8'h01, "rsp rx");
      rd_chk(ADDR_CTRL, 8'h08, 8'hFF, "rsp end");
   endtask : t_rx_header

   task automatic t_uart;
      wr_reg(ADDR_CTRL, 8'h0D);
      wr_reg(ADDR_DLR, 8'h33);
      rd_chk(ADDR_DLR, 8'h00, 8'hFF, "dlr ro");
      i_lin_bus_node.send_wake(8);
      rd_chk(ADDR_STAT, 8'h01, 8'h01, "rx ok");
      rd_chk(ADDR_DAT, 8'hF0, 8'hFF, "rx byte");
      rd_chk(ADDR_STAT, 8'h00, 8'h01, "rx ok clr");
      wr_reg(ADDR_CTRL, 8'h2F);
      wr_reg(ADDR_DAT, 8'hA5);
      repeat (120) @(posedge clk);
      rd_chk(ADDR_STAT, 8'h03, 8'h03, "loop flags");
      rd_chk(ADDR_DAT, 8'hA5, 8'hFF, "loop byte");
   endtask : t_uart

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Whole run needs well under 10000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      srst = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_tx_header();
      t_abort();
      t_rx_header();
      t_uart();
      close_out();
   end
endmodule : lin_uart_command_header_ctrl_tb_top
